// >>> shared/dlp_pkg.sv
// Constants, types and helpers shared by the line protection control block.
package dlp_pkg;
  // ----------------------------------------
  // Bus widths and register offsets.
  // ----------------------------------------
  localparam int DLP_AW = 8;
  localparam int DLP_DW = 8;
  localparam logic [7:0] DLP_OFF_CTRL2 = 8'h11;
  localparam logic [7:0] DLP_OFF_CTRL3 = 8'h12;
  localparam logic [7:0] DLP_OFF_IRQ_STAT = 8'h13;
  localparam logic [7:0] DLP_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] DLP_OFF_PROT_STAT = 8'h15;

  // ----------------------------------------
  // International control 2 fields.
  // ----------------------------------------
  localparam int DLP_C2_RSVD = 7;
  localparam int DLP_C2_MAN_CAL = 6;
  localparam int DLP_C2_CAL_DIS = 5;
  localparam int DLP_C2_ILIM_EN = 4;
  localparam int DLP_C2_OVLD_EN = 3;
  localparam int DLP_C2_BILL_EN = 2;
  localparam int DLP_C2_RX_OVLD = 1;
  localparam int DLP_C2_TONE_DET = 0;
  localparam logic [7:0] DLP_CTRL2_RST = 8'h00;

  // ----------------------------------------
  // International control 3 fields.
  // ----------------------------------------
  localparam int DLP_C3_FULL_SCALE = 7;
  localparam int DLP_C3_ASSIST_A = 6;
  localparam int DLP_C3_FORCE_JT = 5;
  localparam int DLP_C3_VOLT_LOWER = 4;
  localparam int DLP_C3_FORCE_LVT = 3;
  localparam int DLP_C3_MODE = 2;
  localparam int DLP_C3_BIT1 = 1;
  localparam int DLP_C3_BIT0 = 0;
  localparam logic [7:0] DLP_CTRL3_RST = 8'h00;

  // ----------------------------------------
  // Interrupt status, mask and protection status.
  // ----------------------------------------
  localparam int DLP_IRQ_W = 3;
  localparam int DLP_IRQ_RX_OVLD = 0;
  localparam int DLP_IRQ_TONE = 1;
  localparam int DLP_IRQ_OVLD = 2;
  localparam logic [2:0] DLP_IRQ_MASK_RST = 3'h0;
  localparam int DLP_PS_OVLD_DET = 0;
  localparam int DLP_PS_DC_TERM = 1;
  localparam int DLP_PS_Z800 = 2;
  localparam int DLP_PS_ILIM = 3;
  localparam int DLP_PS_STATE = 4;

  // Line status code that trips overload protection.
  localparam logic [3:0] DLP_LINE_TRIP = 4'hf;

  // Protection state, Gray coded along on-hook, live, tripped.
  typedef enum logic [1:0] {
    DLP_ST_ONHOOK = 2'h0,
    DLP_ST_LIVE = 2'h1,
    DLP_ST_OVLD = 2'h3,
    DLP_ST_BILL = 2'h2
  } dlp_state_t;

  // Address match, used by every write decode.
  function automatic logic dlp_hit(input logic [7:0] addr, input logic [7:0] off);
    dlp_hit = (addr == off);
  endfunction
endpackage

// >>> shared/dlp_prot_if.sv
// Interface between the register bank and the protection sequencer.
`timescale 1ns/1ps
interface dlp_prot_if;
  logic ovld_en;
  logic bill_en;
  logic tone_rise;
  logic ovld_trip;
  logic ovld_det;
  logic [1:0] state;
  modport regs (output ovld_en, output bill_en, output tone_rise, input ovld_trip, input ovld_det, input state);
  modport prot (input ovld_en, input bill_en, input tone_rise, output ovld_trip, output ovld_det, output state);
endinterface

// >>> rtl/dlp_sticky.sv
// Bank of sticky flags set by hardware and cleared by software.
`timescale 1ns/1ps
module dlp_sticky #(
  parameter int N = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] q
);
  // ----------------------------------------
  // One flag per bit.
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // A set in the clearing cycle wins, so no event is lost.
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// >>> rtl/dlp_protect.sv
// Sequencer for overload and billing tone protection of the line termination.
`timescale 1ns/1ps
module dlp_protect
  import dlp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic off_hook,
  input wire logic [3:0] line_voltage_current_status,
  dlp_prot_if.prot pif
);
  // ----------------------------------------
  // State register.
  // ----------------------------------------
  dlp_state_t state_q;
  dlp_state_t state_d;
  logic ovld_det_q;
  logic trip;

  assign trip = pif.ovld_en && (line_voltage_current_status == DLP_LINE_TRIP);
  assign pif.state = state_q;
  assign pif.ovld_det = ovld_det_q;
  assign pif.ovld_trip = (state_q == DLP_ST_LIVE) && off_hook && trip;

  // Going on-hook always ends any protection state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      DLP_ST_ONHOOK: begin
        if (off_hook) begin
          state_d = DLP_ST_LIVE;
        end
      end
      DLP_ST_LIVE: begin
        if (trip) begin
          state_d = DLP_ST_OVLD;
        end else if (pif.bill_en && pif.tone_rise) begin
          state_d = DLP_ST_BILL;
        end
      end
      DLP_ST_OVLD: begin
        if (!pif.ovld_en) begin
          state_d = DLP_ST_LIVE;
        end
      end
      DLP_ST_BILL: begin
        if (!pif.bill_en) begin
          state_d = DLP_ST_LIVE;
        end
      end
      default: state_d = DLP_ST_ONHOOK;
    endcase
    if (!off_hook) begin
      state_d = DLP_ST_ONHOOK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= DLP_ST_ONHOOK;
    end else begin
      state_q <= state_d;
    end
  end

  // Detected flag holds until protection is switched off.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovld_det_q <= 1'b0;
    end else if (pif.ovld_trip) begin
      ovld_det_q <= 1'b1;
    end else if (!pif.ovld_en) begin
      ovld_det_q <= 1'b0;
    end
  end
endmodule

// >>> rtl/dlp_top.sv
// Register bank and line protection control of the line access arrangement.
`timescale 1ns/1ps

module dlp_top
  import dlp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic off_hook,
  input wire logic ctr21_mode,
  input wire logic [3:0] line_voltage_current_status,
  input wire logic rx_below_ground,
  input wire logic billing_tone_seen,
  input wire logic rx_track_in,
  output logic termination_tracking_pin,
  output logic dc_term_enable,
  output logic hook_current_reduce,
  output logic present_800_ohm,
  output logic current_limit_active,
  output logic overload_detected_flag,
  output logic manual_cal,
  output logic cal_disable,
  output logic full_scale,
  output logic assist_a,
  output logic force_japan_termination,
  output logic line_voltage_lower,
  output logic force_low_voltage_termination,
  output logic ctrl3_mode,
  output logic ctrl3_bit1_control,
  output logic ctrl3_bit0_control,
  output logic irq
);

  // ----------------------------------------
  // Declarations.
  // ----------------------------------------
  dlp_prot_if pif ();

  logic wr_c2;
  logic wr_c3;
  logic wr_ist;
  logic wr_imk;
  logic man_cal_q;
  logic cal_dis_q;
  logic current_limit_enable_q;
  logic overload_protect_enable_q;
  logic billing_tone_protect_enable_q;
  logic [7:0] ctrl3_q;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] flag_q;
  logic receive_overload_flag;
  logic billing_tone_detected_flag;
  logic tone_prev_q;
  logic [DLP_IRQ_W-1:0] irq_set;
  logic [DLP_IRQ_W-1:0] irq_clr;
  logic [DLP_IRQ_W-1:0] irq_stat;
  logic [DLP_IRQ_W-1:0] irq_mask_q;
  logic track_q;
  logic [7:0] ctrl2_view;
  logic [7:0] prot_view;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Write decode.
  // ----------------------------------------
  // Each write strobe reaches one register only.
  assign wr_c2 = wr && dlp_hit(addr, DLP_OFF_CTRL2);
  assign wr_c3 = wr && dlp_hit(addr, DLP_OFF_CTRL3);
  assign wr_ist = wr && dlp_hit(addr, DLP_OFF_IRQ_STAT);
  assign wr_imk = wr && dlp_hit(addr, DLP_OFF_IRQ_MASK);

  // ----------------------------------------
  // Control 2 enables.
  // ----------------------------------------
  // Reserved bit 7 is dropped on write so it always reads zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      man_cal_q <= DLP_CTRL2_RST[DLP_C2_MAN_CAL];
      cal_dis_q <= DLP_CTRL2_RST[DLP_C2_CAL_DIS];
      current_limit_enable_q <= DLP_CTRL2_RST[DLP_C2_ILIM_EN];
      overload_protect_enable_q <= DLP_CTRL2_RST[DLP_C2_OVLD_EN];
      billing_tone_protect_enable_q <= DLP_CTRL2_RST[DLP_C2_BILL_EN];
    end else if (wr_c2) begin
      man_cal_q <= wdata[DLP_C2_MAN_CAL];
      cal_dis_q <= wdata[DLP_C2_CAL_DIS];
      current_limit_enable_q <= wdata[DLP_C2_ILIM_EN];
      overload_protect_enable_q <= wdata[DLP_C2_OVLD_EN];
      billing_tone_protect_enable_q <= wdata[DLP_C2_BILL_EN];
    end
  end

  // ----------------------------------------
  // Control 3.
  // ----------------------------------------
  // Plain storage; every bit is read/write and resets low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl3_q <= DLP_CTRL3_RST;
    end else if (wr_c3) begin
      ctrl3_q <= wdata;
    end
  end

  assign full_scale = ctrl3_q[DLP_C3_FULL_SCALE];
  assign assist_a = ctrl3_q[DLP_C3_ASSIST_A];
  assign force_japan_termination = ctrl3_q[DLP_C3_FORCE_JT];
  assign line_voltage_lower = ctrl3_q[DLP_C3_VOLT_LOWER];
  assign force_low_voltage_termination = ctrl3_q[DLP_C3_FORCE_LVT];
  assign ctrl3_mode = ctrl3_q[DLP_C3_MODE];
  assign ctrl3_bit1_control = ctrl3_q[DLP_C3_BIT1];
  assign ctrl3_bit0_control = ctrl3_q[DLP_C3_BIT0];
  assign manual_cal = man_cal_q;
  assign cal_disable = cal_dis_q;

  // ----------------------------------------
  // Sticky detection flags.
  // ----------------------------------------
  // Only a written zero clears; a written one is a no-op.
  assign flag_set[0] = billing_tone_seen;
  assign flag_set[1] = rx_below_ground;
  assign flag_clr[0] = wr_c2 && !wdata[DLP_C2_TONE_DET];
  assign flag_clr[1] = wr_c2 && !wdata[DLP_C2_RX_OVLD];

  dlp_sticky #(
    .N(2)
  ) u_flags (
    .clk(clk),
    .arst_n(arst_n),
    .set(flag_set),
    .clr(flag_clr),
    .q(flag_q)
  );

  assign billing_tone_detected_flag = flag_q[0];
  assign receive_overload_flag = flag_q[1];

  // The tone flag edge, not its level, arms billing protection.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tone_prev_q <= 1'b0;
    end else begin
      tone_prev_q <= billing_tone_detected_flag;
    end
  end

  // ----------------------------------------
  // Protection sequencer.
  // ----------------------------------------
  assign pif.ovld_en = overload_protect_enable_q;
  assign pif.bill_en = billing_tone_protect_enable_q;
  assign pif.tone_rise = billing_tone_detected_flag && !tone_prev_q;

  dlp_protect u_prot (
    .clk(clk),
    .arst_n(arst_n),
    .off_hook(off_hook),
    .line_voltage_current_status(line_voltage_current_status),
    .pif(pif)
  );

  // Termination drive follows the protection state.
  assign dc_term_enable = off_hook && (pif.state != DLP_ST_OVLD);
  assign hook_current_reduce = (pif.state == DLP_ST_OVLD);
  assign present_800_ohm = (pif.state == DLP_ST_OVLD) || (pif.state == DLP_ST_BILL);
  assign overload_detected_flag = pif.ovld_det;

  // The limit request only reaches the termination in CTR21 mode.
  assign current_limit_active = current_limit_enable_q && ctr21_mode && dc_term_enable;

  // ----------------------------------------
  // Termination tracking pin.
  // ----------------------------------------
  // A registered copy keeps the pin glitch free; it freezes
  // while billing tone protection holds the line.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      track_q <= 1'b0;
    end else if (pif.state != DLP_ST_BILL) begin
      track_q <= rx_track_in;
    end
  end

  assign termination_tracking_pin = track_q;

  // ----------------------------------------
  // Interrupts.
  // ----------------------------------------
  // Events are the flag sets and the overload trip.
  assign irq_set[DLP_IRQ_RX_OVLD] = rx_below_ground;
  assign irq_set[DLP_IRQ_TONE] = billing_tone_seen;
  assign irq_set[DLP_IRQ_OVLD] = pif.ovld_trip;
  assign irq_clr = wr_ist ? wdata[DLP_IRQ_W-1:0] : '0;

  dlp_sticky #(
    .N(DLP_IRQ_W)
  ) u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_stat)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q <= DLP_IRQ_MASK_RST;
    end else if (wr_imk) begin
      irq_mask_q <= wdata[DLP_IRQ_W-1:0];
    end
  end

  // Level output; a mask of one lets the bit through.
  assign irq = |(irq_stat & irq_mask_q);

  // ----------------------------------------
  // Read path.
  // ----------------------------------------
  // Views assembled from live state so reads never lag.
  always_comb begin
    ctrl2_view = 8'h00;
    ctrl2_view[DLP_C2_MAN_CAL] = man_cal_q;
    ctrl2_view[DLP_C2_CAL_DIS] = cal_dis_q;
    ctrl2_view[DLP_C2_ILIM_EN] = current_limit_enable_q;
    ctrl2_view[DLP_C2_OVLD_EN] = overload_protect_enable_q;
    ctrl2_view[DLP_C2_BILL_EN] = billing_tone_protect_enable_q;
    ctrl2_view[DLP_C2_RX_OVLD] = receive_overload_flag;
    ctrl2_view[DLP_C2_TONE_DET] = billing_tone_detected_flag;
  end

  always_comb begin
    prot_view = 8'h00;
    prot_view[DLP_PS_OVLD_DET] = pif.ovld_det;
    prot_view[DLP_PS_DC_TERM] = dc_term_enable;
    prot_view[DLP_PS_Z800] = present_800_ohm;
    prot_view[DLP_PS_ILIM] = current_limit_active;
    prot_view[DLP_PS_STATE +: 2] = pif.state;
  end

  // Unmapped addresses read as zero.
  always_comb begin
    case (addr)
      DLP_OFF_CTRL2: rd_mux = ctrl2_view;
      DLP_OFF_CTRL3: rd_mux = ctrl3_q;
      DLP_OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat};
      DLP_OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
      DLP_OFF_PROT_STAT: rd_mux = prot_view;
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;
endmodule

// >>> testbench/dlp_top_sva.sv
// Port-level checks for the line protection control block.
`timescale 1ns/1ps
module dlp_top_chk
  import dlp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic off_hook,
  input wire logic ctr21_mode,
  input wire logic [3:0] line_voltage_current_status,
  input wire logic rx_track_in,
  input wire logic termination_tracking_pin,
  input wire logic dc_term_enable,
  input wire logic hook_current_reduce,
  input wire logic present_800_ohm,
  input wire logic current_limit_active,
  input wire logic overload_detected_flag,
  input wire logic [7:0] c3
);
  // ----------------------------------------
  // Helpers and properties.
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ovld_en_q;
  logic bill;
  // Shadow of the overload enable, since the register is not visible at the ports.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovld_en_q <= 1'b0;
    end else if (wr && addr == DLP_OFF_CTRL2) begin
      ovld_en_q <= wdata[DLP_C2_OVLD_EN];
    end
  end
  // Billing state shows 800 ohm without the overload hook current cut.
  assign bill = present_800_ohm && !hook_current_reduce;
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("Read data not zero outside the read slot.");
  AST_C3_WR: assert property (wr && addr == DLP_OFF_CTRL3 |=> c3 == $past(wdata))
    else $error("Control 3 outputs differ from written value.");
  AST_ILIM: assert property (current_limit_active |-> ctr21_mode && dc_term_enable)
    else $error("Current limit active outside CTR21 termination.");
  AST_TRIP: assert property ($past(arst_n) && off_hook && $past(off_hook) && ovld_en_q &&
    line_voltage_current_status == DLP_LINE_TRIP && !present_800_ohm
    |=> hook_current_reduce && !dc_term_enable && overload_detected_flag)
    else $error("Overload did not trip.");
  AST_OVLD_OUT: assert property (hook_current_reduce |-> !dc_term_enable && present_800_ohm)
    else $error("Overload outputs inconsistent.");
  AST_OVLD_EN_OFF: assert property (hook_current_reduce && !ovld_en_q |=> !hook_current_reduce)
    else $error("Overload held with protection off.");
  AST_FLAG_CLR: assert property (!ovld_en_q |=> !overload_detected_flag)
    else $error("Overload flag set with protection off.");
  AST_TRACK: assert property ($past(arst_n) && !$past(bill) |->
    termination_tracking_pin == $past(rx_track_in))
    else $error("Tracking pin not following receive input.");
  AST_FREEZE: assert property ($past(arst_n) && $past(bill) |-> $stable(termination_tracking_pin))
    else $error("Tracking pin moved in billing state.");
endmodule

bind dlp_top dlp_top_chk dlp_top_chk_i (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .off_hook,
  .ctr21_mode, .line_voltage_current_status, .rx_track_in, .termination_tracking_pin, .dc_term_enable,
  .hook_current_reduce, .present_800_ohm, .current_limit_active, .overload_detected_flag,
  .c3({full_scale, assist_a, force_japan_termination, line_voltage_lower, force_low_voltage_termination,
  ctrl3_mode, ctrl3_bit1_control, ctrl3_bit0_control}));

// >>> testbench/dlp_line_model.sv
// Line-side model: status code, detector pulses and a receive level that moves every cycle.
`timescale 1ns/1ps
module dlp_line_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] code_req,
  input wire logic below_req,
  input wire logic tone_req,
  output logic [3:0] line_voltage_current_status,
  output logic rx_below_ground,
  output logic billing_tone_seen,
  output logic rx_track_in
);
  // The receive level toggles so a frozen tracking pin cannot match by luck.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_voltage_current_status <= 4'h0;
      rx_below_ground <= 1'b0;
      billing_tone_seen <= 1'b0;
      rx_track_in <= 1'b0;
    end else begin
      line_voltage_current_status <= code_req;
      rx_below_ground <= below_req;
      billing_tone_seen <= tone_req;
      rx_track_in <= ~rx_track_in;
    end
  end
endmodule

// >>> testbench/test_dlp_top.sv
// Self-checking bench for the line protection control block.
`timescale 1ns/1ps
module test_dlp_top
  import dlp_pkg::*;
;
  logic clk, arst_n, wr, rd, off_hook, ctr21_mode, below_req, tone_req;
  logic [7:0] addr, wdata, rdata;
  wire [7:0] c3;
  logic [3:0] code_req, lstat;
  logic rxbg, tone, rxt, pin, dcen, hcr, z800, ilim, ovf, irq, mc, cd;
  int err_count = 0;
  int cmp_count = 0;
  dlp_line_model dlp_line_model_i (.clk(clk), .arst_n(arst_n), .code_req(code_req), .below_req(below_req),
    .tone_req(tone_req), .line_voltage_current_status(lstat), .rx_below_ground(rxbg),
    .billing_tone_seen(tone), .rx_track_in(rxt));
  dlp_top dlp_top_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .off_hook(off_hook), .ctr21_mode(ctr21_mode), .line_voltage_current_status(lstat),
    .rx_below_ground(rxbg), .billing_tone_seen(tone), .rx_track_in(rxt), .termination_tracking_pin(pin),
    .dc_term_enable(dcen), .hook_current_reduce(hcr), .present_800_ohm(z800), .current_limit_active(ilim),
    .overload_detected_flag(ovf), .manual_cal(mc), .cal_disable(cd), .full_scale(c3[7]), .assist_a(c3[6]),
    .force_japan_termination(c3[5]), .line_voltage_lower(c3[4]), .force_low_voltage_termination(c3[3]),
    .ctrl3_mode(c3[2]), .ctrl3_bit1_control(c3[1]), .ctrl3_bit0_control(c3[0]), .irq(irq));
  // ----------------------------------------
  // Clock, shared tasks and verdict.
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic br(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  task automatic pulse(input bit t);
    @(posedge clk);
    if (t) tone_req <= 1'b1; else below_req <= 1'b1;
    @(posedge clk);
    tone_req <= 1'b0;
    below_req <= 1'b0;
    tick(3);
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 8'h11; i < 8'h16; i++) br(i[7:0], 8'h00, "reset value");
    br(8'h3c, 8'h00, "unmapped");
  endtask
  task automatic t_ctrl3();
    bw(DLP_OFF_CTRL3, 8'ha5);
    chk("ctrl3 pins", 8'ha5, c3);
    bw(DLP_OFF_CTRL3, 8'h5a);
    br(DLP_OFF_CTRL3, 8'h5a, "ctrl3 read");
    // Calibration bits reach their pins; the reserved top bit is dropped.
    bw(DLP_OFF_CTRL2, 8'he0);
    chk("cal pins", 8'h03, {6'h00, mc, cd});
    br(DLP_OFF_CTRL2, 8'h60, "ctrl2 reserved");
    bw(DLP_OFF_CTRL2, 8'h00);
    chk("cal pins off", 8'h00, {6'h00, mc, cd});
  endtask
  // Sticky flags: set by detectors, kept on writing one, cleared on zero; irq masked, raised, cleared.
  task automatic t_sticky();
    pulse(1'b0);
    br(DLP_OFF_CTRL2, 8'h02, "rx overload set");
    chk("irq masked", 8'h00, {7'h00, irq});
    bw(DLP_OFF_IRQ_MASK, 8'h01);
    chk("irq raised", 8'h01, {7'h00, irq});
    bw(DLP_OFF_IRQ_STAT, 8'h01);
    chk("irq cleared", 8'h00, {7'h00, irq});
    bw(DLP_OFF_CTRL2, 8'h02);
    br(DLP_OFF_CTRL2, 8'h02, "rx overload kept");
    bw(DLP_OFF_CTRL2, 8'h00);
    br(DLP_OFF_CTRL2, 8'h00, "rx overload clear");
    pulse(1'b1);
    br(DLP_OFF_CTRL2, 8'h01, "tone flag set");
    bw(DLP_OFF_CTRL2, 8'h01);
    br(DLP_OFF_CTRL2, 8'h01, "tone flag kept");
    bw(DLP_OFF_CTRL2, 8'h00);
    br(DLP_OFF_CTRL2, 8'h00, "tone flag clear");
  endtask
  task automatic t_ilim();
    @(posedge clk) off_hook <= 1'b1;
    bw(DLP_OFF_CTRL2, 8'h10);
    tick(2);
    chk("ilim off mode", 8'h00, {7'h00, ilim});
    @(posedge clk) ctr21_mode <= 1'b1;
    tick(2);
    chk("ilim ctr21", 8'h01, {7'h00, ilim});
    bw(DLP_OFF_CTRL2, 8'h00);
    chk("ilim cleared", 8'h00, {7'h00, ilim});
  endtask
  task automatic t_ovld();
    @(posedge clk) code_req <= 4'hf;
    tick(3);
    chk("no trip", 8'h01, {7'h00, dcen});
    bw(DLP_OFF_CTRL2, 8'h08);
    tick(2);
    chk("trip outputs", 8'h0f, {4'h0, ~dcen, hcr, z800, ovf});
    br(DLP_OFF_PROT_STAT, 8'h35, "prot status");
    @(posedge clk) code_req <= 4'h0;
    bw(DLP_OFF_CTRL2, 8'h00);
    tick(2);
    chk("released", 8'h04, {5'h00, dcen, hcr, ovf});
  endtask
  task automatic t_bill();
    logic p;
    pulse(1'b1);
    chk("bill prot off", 8'h00, {7'h00, z800});
    bw(DLP_OFF_CTRL2, 8'h04);
    pulse(1'b1);
    chk("bill outputs", 8'h05, {5'h00, z800, hcr, dcen});
    p = pin;
    tick(3);
    chk("frozen", {7'h00, p}, {7'h00, pin});
    bw(DLP_OFF_CTRL2, 8'h00);
    tick(2);
    p = pin;
    tick(1);
    chk("tracking", {7'h00, ~p}, {7'h00, pin});
  endtask
  // Reset for six cycles, then run the scenarios; a watchdog cuts any hang short.
  initial begin
    {arst_n, wr, rd, off_hook, ctr21_mode, below_req, tone_req} = 7'h00;
    {addr, wdata, code_req} = 20'h00000;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_ctrl3();
    t_sticky();
    t_ilim();
    t_ovld();
    t_bill();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
